// ==== rtl/serial_link_trigger.v ====
// Serial port, unit link discovery and external trigger control of a display unit.
// Function
// - Trigger ON sends measured value over transmit line
// - Low input ON when low, high input when high
// - All three trigger inputs behave identically
// - Trigger beats simultaneous parallel output request
// - Receive RXD, drive TXD, sample CTS, drive RTS
// - Unit number decoded from two switches, default one
// - Unit one is host; others are terminals
// - Duplicate number or missing host blocks linking
// - At most four units behind one port
// - Output control switch ON skips CTS wait
// - Units exchange unit count before linked operation
// - No terminals within three seconds: link unrecognized
// - Only the host honours its trigger inputs
// - Fast mode fires on trigger without debouncing
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "serial_link_trigger_defs.vh"
module serial_link_trigger #(
  parameter WINDOW_CYCLES = `LINK_WINDOW_S * `CLK_HZ,
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_US * `CLK_MHZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rxd,
  output reg txd,
  input wire cts,
  output wire rts,
  input wire [1:0] unit_switch_on,
  input wire output_control_on,
  input wire trigger_in_low_active,
  input wire trigger_in_high_active,
  input wire external_output_trigger_n,
  input wire parallel_output_request,
  output wire parallel_output_grant,
  input wire [3:0] link_peer_present,
  input wire link_duplicate,
  output reg [7:0] link_fwd_data,
  output reg link_fwd_valid,
  input wire [7:0] link_reply_data,
  input wire link_reply_valid,
  output wire link_reply_ready,
  output wire link_ready,
  output wire link_unrecognized
);
  localparam LS_WAIT = 2'h0;
  localparam LS_OK = 2'h1;
  localparam LS_UNREC = 2'h2;
  localparam LS_FAULT = 2'h3;

  function [7:0] hex_ascii;
    input [3:0] nib;
    begin
      hex_ascii = (nib < 4'hA) ? (`ASCII_ZERO + {4'h0, nib}) : (`ASCII_A_M10 + {4'h0, nib});
    end
  endfunction

  // Every pin input except parallel_output_request and the link reply passes two flip-flops; only the second stage is read.
  // Reset loads each pin's idle level, so no false trigger edge follows reset.
  reg [10:0] sync1_reg;
  reg [10:0] sync2_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 11'h7A8;
      sync2_reg <= 11'h7A8;
    end else begin
      sync1_reg <= {rxd, cts, unit_switch_on, output_control_on, trigger_in_low_active,
                    trigger_in_high_active, external_output_trigger_n, link_peer_present[3:2], link_duplicate};
      sync2_reg <= sync1_reg;
    end
  end
  reg [3:0] peer_s1_reg;
  reg [3:0] peer_s2_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peer_s1_reg <= 4'h0;
      peer_s2_reg <= 4'h0;
    end else begin
      peer_s1_reg <= link_peer_present;
      peer_s2_reg <= peer_s1_reg;
    end
  end
  wire rxd_s = sync2_reg[10];
  wire cts_s = sync2_reg[9];
  wire [1:0] sw_s = sync2_reg[8:7];
  wire no_handshake_s = sync2_reg[6];
  wire dup_s = sync2_reg[0];
  // Any of the three inputs reads ON the same way once polarity is undone.
  wire trig_level = ~sync2_reg[5] | sync2_reg[4] | ~sync2_reg[3];

  // Switch ON,ON is unit 1 (index 0); index 3 is unit 4.
  reg [1:0] unit_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      unit_reg <= 2'h0;
    else
      unit_reg <= {~sw_s[1], ~sw_s[0]};
  end
  wire is_host = (unit_reg == 2'h0);

  // Registers.
  reg [1:0] ctrl_reg;
  reg [31:0] meas_reg;
  reg [15:0] baud_reg;
  wire fast_mode = ctrl_reg[`CTRL_FAST_BIT];
  wire link_en = ctrl_reg[`CTRL_LINK_EN_BIT];

  // Link discovery: the window opens at reset release and runs once.
  reg [1:0] lstate_reg;
  reg [1:0] lstate_next;
  reg [28:0] win_cnt_reg;
  reg [2:0] units_total_reg;
  wire [3:0] others = peer_s2_reg & ~(4'h1 << unit_reg);
  wire clash = dup_s | peer_s2_reg[unit_reg];
  wire [2:0] peer_count = {2'h0, others[0]} + {2'h0, others[1]} + {2'h0, others[2]} + {2'h0, others[3]};
  always @* begin
    lstate_next = lstate_reg;
    case (lstate_reg)
      LS_WAIT: begin
        if (clash)
          lstate_next = LS_FAULT;
        else if (!is_host && others[0])
          lstate_next = LS_OK;
        else if (win_cnt_reg == WINDOW_CYCLES[28:0] - 29'h1)
          lstate_next = (is_host && others != 4'h0) ? LS_OK : LS_UNREC;
      end
      LS_OK: begin
        if (clash)
          lstate_next = LS_FAULT;
      end
      LS_UNREC: lstate_next = LS_UNREC;
      LS_FAULT: lstate_next = LS_FAULT;
      default: lstate_next = LS_WAIT;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lstate_reg <= LS_WAIT;
      win_cnt_reg <= 29'h0;
      units_total_reg <= 3'h1;
    end else begin
      lstate_reg <= lstate_next;
      if (lstate_reg == LS_WAIT)
        win_cnt_reg <= win_cnt_reg + 29'h1;
      if (lstate_reg == LS_WAIT && lstate_next == LS_OK)
        units_total_reg <= peer_count + 3'h1;
    end
  end
  assign link_ready = (lstate_reg == LS_OK);
  assign link_unrecognized = (lstate_reg == LS_UNREC);
  wire may_operate = !link_en || link_ready;

  // Trigger qualification: fast mode takes the raw edge, normal mode waits for a stable level.
  reg [22:0] deb_cnt_reg;
  reg trig_prev_reg;
  reg trig_stable_reg;
  wire raw_rise = trig_level & ~trig_prev_reg;
  wire deb_done = (deb_cnt_reg == DEBOUNCE_CYCLES[22:0] - 23'h1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg <= 1'b0;
      trig_stable_reg <= 1'b0;
      deb_cnt_reg <= 23'h0;
    end else begin
      trig_prev_reg <= trig_level;
      if (trig_level != trig_prev_reg || !trig_level)
        deb_cnt_reg <= 23'h0;
      else if (!deb_done)
        deb_cnt_reg <= deb_cnt_reg + 23'h1;
      trig_stable_reg <= trig_level & deb_done;
    end
  end
  reg stable_prev_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stable_prev_reg <= 1'b0;
    else
      stable_prev_reg <= trig_stable_reg;
  end
  wire deb_rise = trig_stable_reg & ~stable_prev_reg;
  wire trig_fire = (fast_mode ? raw_rise : deb_rise) & is_host & may_operate;

  // Two-entry buffer in front of the transmitter.
  reg [7:0] buf0_reg;
  reg [7:0] buf1_reg;
  reg [1:0] buf_cnt_reg;
  wire buf_in_ready = (buf_cnt_reg != 2'h2);
  wire buf_out_valid = (buf_cnt_reg != 2'h0);
  wire buf_out_ready;

  // Trigger frame: eight hex digits of the measured value then CR LF.
  reg trig_busy_reg;
  reg [3:0] trig_idx_reg;
  reg [31:0] trig_snap_reg;
  reg [7:0] trig_byte;
  always @* begin
    case (trig_idx_reg)
      4'h8: trig_byte = `ASCII_CR;
      4'h9: trig_byte = `ASCII_LF;
      default: trig_byte = hex_ascii(trig_snap_reg[31 - 4 * trig_idx_reg -: 4]);
    endcase
  end
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire tx_wr_req = apb_access & pwrite & (paddr == `OFS_TX_DATA);
  wire src_trig = trig_busy_reg;
  wire src_link = !src_trig && link_reply_valid;
  wire src_apb = !src_trig && !link_reply_valid && tx_wr_req;
  wire buf_in_valid = src_trig | src_link | src_apb;
  wire [7:0] buf_in_data = src_trig ? trig_byte : (src_link ? link_reply_data : pwdata[7:0]);
  wire buf_push = buf_in_valid & buf_in_ready;
  assign link_reply_ready = src_link & buf_in_ready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_busy_reg <= 1'b0;
      trig_idx_reg <= 4'h0;
      trig_snap_reg <= 32'h0000_0000;
    end else if (!trig_busy_reg && trig_fire) begin
      trig_busy_reg <= 1'b1;
      trig_idx_reg <= 4'h0;
      trig_snap_reg <= meas_reg;
    end else if (trig_busy_reg && buf_in_ready) begin
      trig_idx_reg <= trig_idx_reg + 4'h1;
      if (trig_idx_reg == `TRIG_LAST)
        trig_busy_reg <= 1'b0;
    end
  end
  // The parallel request is held off while a trigger fires or its frame is pushed into the buffer.
  assign parallel_output_grant = parallel_output_request & ~trig_fire & ~trig_busy_reg;

  wire buf_pop = buf_out_valid & buf_out_ready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf0_reg <= 8'h00;
      buf1_reg <= 8'h00;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_pop) begin
        buf0_reg <= buf1_reg;
        if (buf_push && buf_cnt_reg == 2'h1)
          buf0_reg <= buf_in_data;
        else if (buf_push)
          buf1_reg <= buf_in_data;
      end else if (buf_push) begin
        if (buf_cnt_reg == 2'h0)
          buf0_reg <= buf_in_data;
        else
          buf1_reg <= buf_in_data;
      end
      buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Transmitter, 8N1; a byte starts only with CTS or with the handshake switched off.
  reg [3:0] tx_bit_reg;
  reg [15:0] tx_div_reg;
  reg [8:0] tx_shift_reg;
  reg tx_busy_reg;
  assign buf_out_ready = !tx_busy_reg && (cts_s || no_handshake_s);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_reg <= 1'b0;
      tx_bit_reg <= 4'h0;
      tx_div_reg <= 16'h0000;
      tx_shift_reg <= 9'h1FF;
      txd <= 1'b1;
    end else if (!tx_busy_reg) begin
      txd <= 1'b1;
      if (buf_pop) begin
        tx_busy_reg <= 1'b1;
        tx_shift_reg <= {1'b1, buf0_reg};
        tx_bit_reg <= 4'h0;
        tx_div_reg <= 16'h0000;
        txd <= 1'b0;
      end
    end else if (tx_div_reg == baud_reg - 16'h1) begin
      tx_div_reg <= 16'h0000;
      tx_bit_reg <= tx_bit_reg + 4'h1;
      txd <= tx_shift_reg[0];
      tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
      if (tx_bit_reg == 4'h9)
        tx_busy_reg <= 1'b0;
    end else begin
      tx_div_reg <= tx_div_reg + 16'h1;
    end
  end

  // Receiver and request routing by leading unit digit.
  reg rx_busy_reg;
  reg [3:0] rx_bit_reg;
  reg [15:0] rx_div_reg;
  reg [7:0] rx_shift_reg;
  reg rx_done_reg;
  reg [7:0] rx_hold_reg;
  reg rx_full_reg;
  reg rx_overrun_reg;
  reg at_start_reg;
  reg forward_reg;
  assign rts = ~rx_full_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_reg <= 1'b0;
      rx_bit_reg <= 4'h0;
      rx_div_reg <= 16'h0000;
      rx_shift_reg <= 8'h00;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rxd_s) begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg <= 4'h0;
          rx_div_reg <= {1'b0, baud_reg[15:1]};
        end
      end else if (rx_div_reg == baud_reg - 16'h1) begin
        rx_div_reg <= 16'h0000;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rxd_s)
          rx_busy_reg <= 1'b0;
        else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          rx_done_reg <= rxd_s;
        end else if (rx_bit_reg != 4'h0)
          rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
      end else begin
        rx_div_reg <= rx_div_reg + 16'h1;
      end
    end
  end
  wire digit_remote = (rx_shift_reg > `ASCII_ONE) && (rx_shift_reg <= `ASCII_FOUR);
  wire route_fwd = is_host && link_en && link_ready && (at_start_reg ? digit_remote : forward_reg);
  wire rx_pop = apb_access & ~pwrite & (paddr == `OFS_RX_DATA);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      at_start_reg <= 1'b1;
      forward_reg <= 1'b0;
      link_fwd_data <= 8'h00;
      link_fwd_valid <= 1'b0;
      rx_hold_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      rx_overrun_reg <= 1'b0;
    end else begin
      link_fwd_valid <= 1'b0;
      if (rx_pop)
        rx_full_reg <= 1'b0;
      if (rx_done_reg) begin
        at_start_reg <= (rx_shift_reg == `ASCII_LF);
        forward_reg <= route_fwd;
        if (route_fwd) begin
          link_fwd_data <= rx_shift_reg;
          link_fwd_valid <= 1'b1;
        end else begin
          rx_hold_reg <= rx_shift_reg;
          rx_full_reg <= 1'b1;
          if (rx_full_reg && !rx_pop)
            rx_overrun_reg <= 1'b1;
        end
      end
    end
  end

  // APB slave: only a TX_DATA write waits, until the buffer takes the byte.
  wire addr_known = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) || (paddr == `OFS_MEAS) ||
                    (paddr == `OFS_TX_DATA) || (paddr == `OFS_RX_DATA) || (paddr == `OFS_BAUD);
  assign pready = !tx_wr_req || (src_apb && buf_in_ready);
  assign pslverr = apb_access & ~addr_known;
  wire wr_done = apb_access & pwrite & pready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      meas_reg <= 32'h0000_0000;
      baud_reg <= `BAUD_DIV_RESET;
    end else if (wr_done) begin
      if (paddr == `OFS_CTRL)
        ctrl_reg <= pwdata[1:0];
      if (paddr == `OFS_MEAS)
        meas_reg <= pwdata;
      if (paddr == `OFS_BAUD && pwdata[15:0] != 16'h0000)
        baud_reg <= pwdata[15:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (apb_setup && !pwrite) begin
      case (paddr)
        `OFS_CTRL: prdata <= {30'h0, ctrl_reg};
        `OFS_STATUS: prdata <= {20'h0, rx_overrun_reg, trig_busy_reg, units_total_reg, lstate_reg,
                                is_host, no_handshake_s, 1'b0, unit_reg};
        `OFS_MEAS: prdata <= meas_reg;
        `OFS_RX_DATA: prdata <= {23'h0, rx_full_reg, rx_hold_reg};
        `OFS_BAUD: prdata <= {16'h0, baud_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== inc/serial_link_trigger_defs.vh ====
// Constants for the serial link and trigger controller.
`ifndef SERIAL_LINK_TRIGGER_DEFS_VH
`define SERIAL_LINK_TRIGGER_DEFS_VH
`define CLK_HZ 100000000
`define CLK_MHZ 100
`define LINK_WINDOW_S 3
`define DEBOUNCE_US 1000
`define BAUD_DIV_RESET 16'h28B1
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_MEAS 12'h008
`define OFS_TX_DATA 12'h00C
`define OFS_RX_DATA 12'h010
`define OFS_BAUD 12'h014
`define CTRL_FAST_BIT 0
`define CTRL_LINK_EN_BIT 1
`define CTRL_RESET 2'h0
`define RX_VALID_BIT 8
`define ASCII_CR 8'h0D
`define ASCII_LF 8'h0A
`define ASCII_ONE 8'h31
`define ASCII_FOUR 8'h34
`define ASCII_ZERO 8'h30
`define ASCII_A_M10 8'h37
`define TRIG_LAST 4'h9
`endif

// ==== tb/serial_peer.sv ====
// Host computer model on the device's serial port.
module serial_peer #(parameter int BIT = 16) (
  input wire pclk,
  input wire txd,
  output logic rxd,
  output wire cts
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  logic [7:0] b;
  logic cts_ok = 1'b1;
  // The request line toward the device's clear-to-send input.
  assign cts = cts_ok;
  initial rxd = 1'b1;
  // Sampling at mid-bit tolerates the device's start-bit jitter of a few cycles.
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      b[i] = txd;
    end
    repeat (BIT) @(posedge pclk);
    rx_q.push_back(b);
  end
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
      repeat (BIT) @(posedge pclk);
    end
  endtask
endmodule

// ==== tb/serial_link_trigger_monitor.sv ====
// Port checker of the serial link and trigger controller.
`include "serial_link_trigger_defs.vh"
module slt_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] unit_switch_on,
  input wire parallel_output_request,
  input wire parallel_output_grant,
  input wire link_duplicate,
  input wire link_fwd_valid,
  input wire link_ready,
  input wire link_unrecognized
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  unmapped_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ready_low_a: assert property (!pready |-> psel && pwrite && paddr == `OFS_TX_DATA)
    else $error("wait state on wrong access");
  grant_req_a: assert property (parallel_output_grant |-> parallel_output_request)
    else $error("grant without request");
  link_excl_a: assert property (!(link_ready && link_unrecognized))
    else $error("link ready and unrecognized");
  fwd_pulse_a: assert property (link_fwd_valid |=> !link_fwd_valid)
    else $error("forward valid too long");
  fwd_ready_a: assert property (link_fwd_valid |-> link_ready)
    else $error("forward before link ready");
  fwd_host_a: assert property (link_fwd_valid |-> unit_switch_on == 2'b11)
    else $error("terminal forwards");
  dup_fwd_a: assert property (link_duplicate [*5] |-> !link_fwd_valid)
    else $error("forward with clash");
  cover property (parallel_output_grant);
  cover property (link_ready);
  cover property (link_fwd_valid);
endmodule
bind serial_link_trigger slt_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .unit_switch_on, .parallel_output_request, .parallel_output_grant, .link_duplicate,
  .link_fwd_valid, .link_ready, .link_unrecognized);

// ==== tb/serial_link_trigger_tb.sv ====
// Self-checking testbench of the serial link and trigger controller.
`include "serial_link_trigger_defs.vh"
module serial_link_trigger_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 16;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, rxd, txd, cts, rts, output_control_on = 0, parallel_output_grant;
  logic trigger_in_low_active = 1, trigger_in_high_active = 0, external_output_trigger_n = 1;
  logic parallel_output_request = 0, link_duplicate = 0, link_fwd_valid, link_reply_valid = 0;
  logic link_reply_ready, link_ready, link_unrecognized;
  logic [1:0] unit_switch_on = 2'b11;
  logic [3:0] link_peer_present = 0;
  logic [7:0] link_fwd_data, link_reply_data = 0, fq[$];
  int mismatches = 0, num_checks = 0, cyc = 0;
  serial_link_trigger #(.WINDOW_CYCLES(200), .DEBOUNCE_CYCLES(8)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .cts, .rts, .unit_switch_on, .output_control_on,
    .trigger_in_low_active, .trigger_in_high_active, .external_output_trigger_n, .parallel_output_request,
    .parallel_output_grant, .link_peer_present, .link_duplicate, .link_fwd_data, .link_fwd_valid,
    .link_reply_data, .link_reply_valid, .link_reply_ready, .link_ready, .link_unrecognized);
  serial_peer #(.BIT(BIT)) peer (.pclk, .txd, .rxd, .cts);
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (link_fwd_valid) fq.push_back(link_fwd_data);
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 4000 && peer.rx_q.size() < n; i++) @(posedge pclk);
  endtask
  function automatic logic [7:0] hex(input logic [3:0] n);
    return n < 10 ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic frame_check(input logic [31:0] v);
    wait_bytes(10);
    chk(32'(peer.rx_q.size()), 32'd10);
    for (int i = 0; i < 8; i++) chk(32'(peer.rx_q[i]), 32'(hex(v[31 - 4 * i -: 4])));
    chk({peer.rx_q[8], peer.rx_q[9]}, {`ASCII_CR, `ASCII_LF});
    peer.rx_q.delete();
  endtask
  // One input index: 0 low-active, 1 high-active, 2 jack.
  task automatic pulse(input int k, input int len = 4);
    trigger_in_low_active <= (k != 0);
    trigger_in_high_active <= (k == 1);
    external_output_trigger_n <= (k != 2);
    repeat (len) @(posedge pclk);
    trigger_in_low_active <= 1;
    trigger_in_high_active <= 0;
    external_output_trigger_n <= 1;
    @(posedge pclk);
  endtask
  task automatic test_regs();
    apb(0, `OFS_STATUS, 0);
    chk(rd[4], 1);
    chk(rts, 1);
    apb(0, `OFS_BAUD, 0);
    chk(rd, 32'(`BAUD_DIV_RESET));
    apb(0, 12'h018, 0);
    chk({se, rd}, {1'b1, 32'h0000_0000});
    apb(1, `OFS_BAUD, BIT);
    for (int i = 0; i < 4; i++) apb(1, `OFS_TX_DATA, 32'h0000_0041 + i);
    wait_bytes(4);
    for (int i = 0; i < 4; i++) chk(32'(peer.rx_q[i]), 32'h0000_0041 + i);
    peer.rx_q.delete();
    peer.send(8'h5A);
    repeat (20) @(posedge pclk);
    chk(rts, 0);
    apb(0, `OFS_RX_DATA, 0);
    chk(rd, 32'h0000_015A);
    chk(rts, 1);
    repeat (250) @(posedge pclk);
    chk(link_unrecognized, 1);
    $display("register test done");
  endtask
  task automatic test_trig();
    apb(1, `OFS_MEAS, 32'h1234_ABCD);
    apb(1, `OFS_CTRL, 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      frame_check(32'h1234_ABCD);
    end
    // Normal mode must drop a short pulse and take a level that is held.
    apb(1, `OFS_CTRL, 32'h0000_0000);
    pulse(0);
    repeat (200) @(posedge pclk);
    chk(32'(peer.rx_q.size()), 0);
    pulse(0, 20);
    frame_check(32'h1234_ABCD);
    apb(1, `OFS_CTRL, 32'h0000_0001);
    $display("trigger test done");
  endtask
  task automatic test_prio();
    parallel_output_request <= 1;
    pulse(1);
    chk(parallel_output_grant, 0);
    frame_check(32'h1234_ABCD);
    chk(parallel_output_grant, 1);
    parallel_output_request <= 0;
    $display("priority test done");
  endtask
  task automatic test_cts();
    peer.cts_ok <= 0;
    pulse(0);
    repeat (2000) @(posedge pclk);
    chk(32'(peer.rx_q.size()), 0);
    output_control_on <= 1;
    frame_check(32'h1234_ABCD);
    peer.cts_ok <= 1;
    output_control_on <= 0;
    $display("handshake test done");
  endtask
  task automatic test_link();
    logic [7:0] req[5] = '{8'h32, 8'h41, 8'h52, `ASCII_CR, `ASCII_LF};
    int n = 0;
    presetn <= 0;
    link_peer_present <= 4'b0010;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(1, `OFS_BAUD, BIT);
    apb(1, `OFS_CTRL, 32'h0000_0003);
    repeat (250) @(posedge pclk);
    chk(link_ready, 1);
    apb(0, `OFS_STATUS, 0);
    chk(rd[9:7], 3'h2);
    foreach (req[i]) peer.send(req[i]);
    repeat (40) @(posedge pclk);
    chk(32'(fq.size()), 5);
    foreach (fq[i]) chk(32'(fq[i]), 32'(req[i]));
    link_reply_data <= 8'h4F;
    link_reply_valid <= 1;
    do @(posedge pclk); while (!link_reply_ready && ++n < 1000);
    link_reply_valid <= 0;
    wait_bytes(1);
    chk(32'(peer.rx_q[0]), 32'h0000_004F);
    peer.rx_q.delete();
    link_duplicate <= 1;
    repeat (6) @(posedge pclk);
    chk(link_ready, 0);
    // With the link off a host would fire, so only the unit number can stop this trigger.
    apb(1, `OFS_CTRL, 32'h0000_0001);
    unit_switch_on <= 2'b10;
    repeat (4) @(posedge pclk);
    apb(0, `OFS_STATUS, 0);
    chk(rd[4:0], 5'h01);
    pulse(1);
    repeat (300) @(posedge pclk);
    chk(32'(peer.rx_q.size()), 0);
    $display("link test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    test_regs();
    test_trig();
    test_prio();
    test_cts();
    test_link();
    final_report();
  end
endmodule
